// ==== rtl/light_consts.svh ====
// Constants of the light sensor register bank: offsets, fields, resets, times.
`ifndef LIGHT_CONSTS_SVH
`define LIGHT_CONSTS_SVH

`define CYC_PER_MS        200000
`define INTEG_MAX_MS      800
`define PERSIST_STEP_MS   100
`define I2C_ADDR_BASE     6'h25

`define REG_FLAG          8'h00
`define REG_ENABLE        8'h01
`define REG_CONFIG        8'h02
`define REG_RESULT_UPPER  8'h03
`define REG_RESULT_LOWER  8'h04
`define REG_UPPER_LIMIT   8'h05
`define REG_LOWER_LIMIT   8'h06
`define REG_PERSIST_TIME  8'h07

`define CFG_REPEAT_BIT    7
`define CFG_MANUAL_BIT    6
`define CFG_CDR_BIT       3
`define CFG_TIM_MSB       2

`define DEFAULT_TIM       3'h3
`define UPPER_RESET       8'hff
`define LOWER_RESET       8'h00
`define PERSIST_RESET     8'hff
`define RESULT_RESET      12'h000
`define EXP_OVERRANGE     4'hf
`define AUTO_BRIGHT_EXP   4'h8
`define AUTO_DIM_MANT     4'h1

`endif

// ==== rtl/light_pkg.sv ====
// Types and shared arithmetic of the light sensor register bank.
package light_pkg;

	typedef enum logic [3:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_ADDR_ACK,
		I2C_PTR,
		I2C_PTR_ACK,
		I2C_WR,
		I2C_WR_ACK,
		I2C_TX,
		I2C_TX_ACK
	} i2c_state_e;

	typedef struct packed {
		logic [1:0]  scl_sync;
		logic [1:0]  sda_sync;
		logic [1:0]  asel_sync;
		logic        scl_q;
		logic        sda_q;
		i2c_state_e  st;
		logic        rd_mode;
		logic [3:0]  bit_cnt;
		logic [7:0]  shift;
		logic [7:0]  ptr;
		logic        sda_oe;
		logic        int_oe;
		logic        pin_low;
		logic        freeze;
		logic        pend_valid;
		logic [11:0] pend_code;
		logic        outside;
		logic        flag;
		logic        enable;
		logic        repeat_measure;
		logic        manual;
		logic        divide_by_eight;
		logic [2:0]  integration_select;
		logic [11:0] result;
		logic [7:0]  upper_limit;
		logic [7:0]  lower_limit;
		logic [7:0]  persist_time;
	} top_s;

	typedef struct packed {
		logic [31:0] cnt;
		logic [11:0] code;
		logic        done;
		logic [2:0]  auto_tim;
		logic        auto_cdr;
	} seq_s;

	typedef struct packed {
		logic [31:0] div;
		logic [8:0]  persist_count;
		logic        hit;
	} persist_s;

	// Mantissa shifted by exponent, so bytes compare as light levels.
	function automatic logic [18:0] lux_value(input logic [7:0] b);
		lux_value = {15'h0000, b[3:0]} << b[7:4];
	endfunction

endpackage

// ==== rtl/meas_if.sv ====
// Measurement control and result signals between register bank and sequencer.
interface meas_if;
	logic        repeat_measure;
	logic        manual;
	logic [2:0]  tim_user;
	logic        cdr_user;
	logic [2:0]  tim_eff;
	logic        cdr_eff;
	logic        done;
	logic [11:0] code;

	modport seq (
		input  repeat_measure, manual, tim_user, cdr_user,
		output tim_eff, cdr_eff, done, code
	);
	modport ctl (
		output repeat_measure, manual, tim_user, cdr_user,
		input  tim_eff, cdr_eff, done, code
	);
endinterface

// ==== rtl/measure_sequencer.sv ====
// Measurement cadence, result capture and automatic range selection.
`include "light_consts.svh"
module measure_sequencer
	import light_pkg::*;
#(
	parameter int unsigned INTEG_MAX_CYCLES = `INTEG_MAX_MS * `CYC_PER_MS
)(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [11:0] adc_code,
	meas_if.seq              mif
);

	seq_s r;
	seq_s n;
	logic [31:0] period;

	assign mif.tim_eff = mif.manual ? mif.tim_user : r.auto_tim;
	assign mif.cdr_eff = mif.manual ? mif.cdr_user : r.auto_cdr;
	assign mif.done    = r.done;
	assign mif.code    = r.code;

	always_comb
	begin
		n = r;
		n.done = 1'b0;
		// One-shot mode keeps the slow cadence to save supply current.
		period = mif.repeat_measure ?
			(INTEG_MAX_CYCLES >> mif.tim_eff) : INTEG_MAX_CYCLES;
		if (r.cnt >= period - 32'd1)
		begin
			n.cnt = '0;
			n.done = 1'b1;
			n.code = adc_code;
			if (adc_code[11:8] == `EXP_OVERRANGE)
				n.auto_cdr = 1'b1;
			else if (adc_code[11:8] >= `AUTO_BRIGHT_EXP && r.auto_tim < `DEFAULT_TIM)
				n.auto_tim = r.auto_tim + 3'h1;
			else if (adc_code[11:4] <= {4'h0, `AUTO_DIM_MANT})
			begin
				if (r.auto_cdr)
					n.auto_cdr = 1'b0;
				else if (r.auto_tim != 3'h0)
					n.auto_tim = r.auto_tim - 3'h1;
			end
		end
		else
			n.cnt = r.cnt + 32'd1;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.code <= `RESULT_RESET;
			r.auto_tim <= `DEFAULT_TIM;
		end
		else
			r <= n;
	end

endmodule // measure_sequencer

// ==== rtl/persist_timer.sv ====
// Counts how long light stays outside the window and flags the excursion.
`include "light_consts.svh"
module persist_timer
	import light_pkg::*;
#(
	parameter int unsigned PERSIST_STEP_CYCLES = `PERSIST_STEP_MS * `CYC_PER_MS
)(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       outside,
	input  wire logic [7:0] persist_time,
	output logic            hit
);

	persist_s r;
	persist_s n;

	assign hit = r.hit;

	always_comb
	begin
		n = r;
		n.hit = 1'b0;
		if (!outside)
		begin
			n.div = '0;
			n.persist_count = '0;
		end
		else if (r.div >= PERSIST_STEP_CYCLES - 32'd1)
		begin
			n.div = '0;
			if (r.persist_count <= {1'b0, persist_time})
				n.persist_count = r.persist_count + 9'h001;
			// Fires once per excursion so a cleared flag stays clear.
			n.hit = (r.persist_count == {1'b0, persist_time});
		end
		else
			n.div = r.div + 32'd1;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			r <= '0;
		else
			r <= n;
	end

endmodule // persist_timer

// ==== rtl/light_sensor_regs_irq.sv ====
// I2C target, register bank and threshold flag of the light sensor.
`include "light_consts.svh"
module light_sensor_regs_irq
	import light_pkg::*;
#(
	parameter int unsigned INTEG_MAX_CYCLES    = `INTEG_MAX_MS * `CYC_PER_MS,
	parameter int unsigned PERSIST_STEP_CYCLES = `PERSIST_STEP_MS * `CYC_PER_MS
)(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        addr_select_pin,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             int_n_o,
	output logic             int_n_oe,
	input  wire logic [11:0] adc_code,
	output logic [2:0]       integration_select,
	output logic             divide_by_eight
);

	top_s   r;
	top_s   n;
	meas_if mif ();
	logic   hit;
	logic   scl_rise;
	logic   scl_fall;
	logic   start_cond;
	logic   stop_cond;
	logic   addr_match;
	logic   event_set;
	logic   flag_clear;
	logic [7:0] rd_byte;

	measure_sequencer #(
		.INTEG_MAX_CYCLES (INTEG_MAX_CYCLES)
	) u_seq (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.adc_code (adc_code),
		.mif      (mif)
	);

	persist_timer #(
		.PERSIST_STEP_CYCLES (PERSIST_STEP_CYCLES)
	) u_persist (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.outside      (r.outside),
		.persist_time (r.persist_time),
		.hit          (hit)
	);

	assign mif.repeat_measure = r.repeat_measure;
	assign mif.manual         = r.manual;
	assign mif.tim_user       = r.integration_select;
	assign mif.cdr_user       = r.divide_by_eight;

	// The pins only ever sink current; the board supplies the high level.
	assign sda_o              = r.pin_low;
	assign sda_oe             = r.sda_oe;
	assign int_n_o            = r.pin_low;
	assign int_n_oe           = r.int_oe;
	assign integration_select = mif.tim_eff;
	assign divide_by_eight    = mif.cdr_eff;

	assign scl_rise   = r.scl_sync[1] & ~r.scl_q;
	assign scl_fall   = ~r.scl_sync[1] & r.scl_q;
	assign start_cond = r.scl_sync[1] & r.scl_q & r.sda_q & ~r.sda_sync[1];
	assign stop_cond  = r.scl_sync[1] & r.scl_q & ~r.sda_q & r.sda_sync[1];
	assign addr_match = (r.shift[7:1] == {`I2C_ADDR_BASE, r.asel_sync[1]});

	always_comb
	begin
		unique case (r.ptr)
			`REG_FLAG:         rd_byte = {7'h00, r.flag};
			`REG_ENABLE:       rd_byte = {7'h00, r.enable};
			`REG_CONFIG:       rd_byte = {r.repeat_measure, r.manual, 2'b00,
				mif.cdr_eff, mif.tim_eff};
			`REG_RESULT_UPPER: rd_byte = r.result[11:4];
			`REG_RESULT_LOWER: rd_byte = {4'h0, r.result[3:0]};
			`REG_UPPER_LIMIT:  rd_byte = r.upper_limit;
			`REG_LOWER_LIMIT:  rd_byte = r.lower_limit;
			`REG_PERSIST_TIME: rd_byte = r.persist_time;
			default:           rd_byte = 8'h00;
		endcase
	end

	always_comb
	begin
		n = r;
		flag_clear = 1'b0;
		n.scl_sync = {r.scl_sync[0], scl_i};
		n.sda_sync = {r.sda_sync[0], sda_i};
		n.asel_sync = {r.asel_sync[0], addr_select_pin};
		n.scl_q = r.scl_sync[1];
		n.sda_q = r.sda_sync[1];

		if (start_cond)
		begin
			n.st = I2C_ADDR;
			n.bit_cnt = 4'h0;
			n.sda_oe = 1'b0;
		end
		else if (stop_cond)
		begin
			n.st = I2C_IDLE;
			n.sda_oe = 1'b0;
			n.freeze = 1'b0;
			if (r.pend_valid)
				n.result = r.pend_code;
			n.pend_valid = 1'b0;
		end
		else
		begin
			unique case (r.st)
				I2C_IDLE: ;
				I2C_ADDR, I2C_PTR, I2C_WR:
				begin
					if (scl_rise)
					begin
						n.shift = {r.shift[6:0], r.sda_sync[1]};
						n.bit_cnt = r.bit_cnt + 4'h1;
					end
					else if (scl_fall && r.bit_cnt == 4'h8)
					begin
						n.sda_oe = 1'b1;
						n.bit_cnt = 4'h0;
						if (r.st == I2C_ADDR)
						begin
							if (addr_match)
							begin
								n.st = I2C_ADDR_ACK;
								n.rd_mode = r.shift[0];
								n.freeze = 1'b1;
							end
							else
							begin
								n.st = I2C_IDLE;
								n.sda_oe = 1'b0;
							end
						end
						else if (r.st == I2C_PTR)
						begin
							n.ptr = r.shift;
							n.st = I2C_PTR_ACK;
						end
						else
						begin
							n.st = I2C_WR_ACK;
							n.ptr = r.ptr + 8'h01;
							unique case (r.ptr)
								`REG_ENABLE:
								begin
									n.enable = r.shift[0];
									flag_clear = ~r.shift[0];
								end
								`REG_CONFIG:
								begin
									n.repeat_measure = r.shift[`CFG_REPEAT_BIT];
									n.manual = r.shift[`CFG_MANUAL_BIT];
									// Timing fields belong to autoranging
									// unless the host holds them.
									if (r.manual)
									begin
										n.divide_by_eight = r.shift[`CFG_CDR_BIT];
										n.integration_select =
											r.shift[`CFG_TIM_MSB:0];
									end
								end
								`REG_UPPER_LIMIT:  n.upper_limit = r.shift;
								`REG_LOWER_LIMIT:  n.lower_limit = r.shift;
								`REG_PERSIST_TIME: n.persist_time = r.shift;
								default: ;
							endcase
						end
					end
				end
				I2C_ADDR_ACK, I2C_PTR_ACK, I2C_WR_ACK, I2C_TX_ACK:
				begin
					if (scl_rise && r.st == I2C_TX_ACK && r.sda_sync[1])
						n.st = I2C_IDLE;
					else if (scl_fall)
					begin
						n.sda_oe = 1'b0;
						n.bit_cnt = 4'h0;
						if ((r.st == I2C_ADDR_ACK && r.rd_mode) ||
							r.st == I2C_TX_ACK)
						begin
							n.st = I2C_TX;
							n.shift = rd_byte;
							n.sda_oe = ~rd_byte[7];
							n.ptr = r.ptr + 8'h01;
							flag_clear = (r.ptr == `REG_FLAG);
						end
						else if (r.st == I2C_ADDR_ACK)
							n.st = I2C_PTR;
						else
							n.st = I2C_WR;
					end
				end
				I2C_TX:
				begin
					if (scl_fall)
					begin
						n.bit_cnt = r.bit_cnt + 4'h1;
						if (r.bit_cnt == 4'h7)
						begin
							n.st = I2C_TX_ACK;
							n.sda_oe = 1'b0;
						end
						else
						begin
							n.shift = {r.shift[6:0], 1'b0};
							n.sda_oe = ~r.shift[6];
						end
					end
				end
			endcase
		end

		if (mif.done)
		begin
			if (n.freeze)
			begin
				n.pend_valid = 1'b1;
				n.pend_code = mif.code;
			end
			else
				n.result = mif.code;
		end

		n.outside = (lux_value(mif.code[11:4]) > lux_value(r.upper_limit)) ||
			(lux_value(mif.code[11:4]) < lux_value(r.lower_limit));

		// A hit in the clearing cycle survives the clear.
		event_set = hit & r.enable;
		if (flag_clear)
			n.flag = 1'b0;
		if (event_set)
			n.flag = 1'b1;
		n.int_oe = n.flag;
		n.pin_low = 1'b0;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			r <= '0;
			r.st <= I2C_IDLE;
			r.scl_sync <= 2'h3;
			r.sda_sync <= 2'h3;
			r.scl_q <= 1'b1;
			r.sda_q <= 1'b1;
			r.integration_select <= `DEFAULT_TIM;
			r.result <= `RESULT_RESET;
			r.pend_code <= `RESULT_RESET;
			r.upper_limit <= `UPPER_RESET;
			r.lower_limit <= `LOWER_RESET;
			r.persist_time <= `PERSIST_RESET;
		end
		else
			r <= n;
	end

endmodule // light_sensor_regs_irq

// ==== bench/light_sensor_regs_irq_asserts.sv ====
// Pin-level checks of the light sensor register bank.
module light_sensor_asserts #(
	parameter int unsigned INTEG_MAX_CYCLES = 1280
)(
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       scl_i,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic       int_n_o,
	input wire logic       int_n_oe,
	input wire logic [2:0] integration_select,
	input wire logic       divide_by_eight
);
	logic [31:0] idle_reg;
	logic [31:0] age_reg;

	// The flag may only drop through bus traffic, so idle time is counted.
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
		begin
			idle_reg <= 32'h0;
			age_reg  <= 32'h0;
		end
		else
		begin
			idle_reg <= (scl_i && sda_i) ? idle_reg + 32'h1 : 32'h0;
			age_reg  <= age_reg + 32'h1;
		end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_int_only_low: assert property (int_n_o == 1'b0)
		else $error("interrupt pin driven high");
	chk_sda_only_low: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	chk_reset_quiet: assert property ($fell(rst) |->
		!sda_oe && !int_n_oe && integration_select == 3'h3 && !divide_by_eight)
		else $error("wrong pin state after reset");
	chk_drive_after_fall: assert property ($rose(sda_oe) |->
		!scl_i && $past(scl_i, 6))
		else $error("data pull outside the low clock phase");
	chk_release_after_fall: assert property ($fell(sda_oe) |->
		!scl_i && $past(scl_i, 6))
		else $error("data release outside the low clock phase");
	chk_drive_holds: assert property ($rose(sda_oe) |=> sda_oe [*8])
		else $error("data pull too short");
	chk_flag_holds: assert property (int_n_oe && idle_reg > 32'h8 |=> int_n_oe)
		else $error("interrupt released on an idle bus");
	chk_flag_not_early: assert property ($rose(int_n_oe) |->
		age_reg > INTEG_MAX_CYCLES)
		else $error("interrupt before any measurement");
	cover property ($rose(int_n_oe));
	cover property ($fell(int_n_oe));
	cover property ($rose(sda_oe) ##1 sda_oe [*8]);
endmodule // light_sensor_asserts

bind light_sensor_regs_irq light_sensor_asserts #(
	.INTEG_MAX_CYCLES(INTEG_MAX_CYCLES)
) chk_u (
	.clk_sys(clk_sys), .rst(rst), .scl_i(scl_i), .sda_i(sda_i),
	.sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe),
	.integration_select(integration_select),
	.divide_by_eight(divide_by_eight)
);

// ==== bench/i2c_host_model.sv ====
// Behavioural I2C controller that reaches the sensor's registers.
module i2c_host_model #(
	parameter int unsigned QTR = 8
)(
	input  wire logic  clk_sys,
	input  wire logic  sda_line,
	output logic       scl,
	output logic       sda_low,
	output logic       rd_done,
	output logic [8:0] rd_word
);
	timeunit 1ns;
	timeprecision 1ps;

	// The clock stands high and the data line is released between frames.
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
		rd_done = 1'b0;
		rd_word = 9'h000;
	end

	task automatic step(input logic c, input logic d);
		scl <= c;
		sda_low <= d;
		repeat (QTR) @(posedge clk_sys);
	endtask

	task automatic bit_io(input logic b, output logic r);
		step(1'b0, !b);
		step(1'b1, !b);
		r = sda_line;
		step(1'b1, !b);
		step(1'b0, !b);
	endtask

	// Serves as START and as repeated START.
	task automatic start();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
		step(1'b0, 1'b1);
	endtask

	task automatic stop();
		step(1'b0, 1'b1);
		step(1'b1, 1'b1);
		step(1'b1, 1'b0);
		step(1'b1, 1'b0);
	endtask

	task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
			bit_io(tx[i], rx[i]);
	endtask

	task automatic wr_reg(input logic [6:0] a, input logic [7:0] p,
		input logic [7:0] d);
		logic [8:0] r;
		start();
		byte_io({a, 2'b01}, r);
		byte_io({p, 1'b1}, r);
		byte_io({d, 1'b1}, r);
		stop();
	endtask

	// Reports {address refused, data}; the last byte is refused as usual.
	task automatic rd_reg(input logic [6:0] a, input logic [7:0] p);
		logic [8:0] r;
		start();
		byte_io({a, 2'b01}, r);
		if (r[0] === 1'b0)
		begin
			byte_io({p, 1'b1}, r);
			start();
			byte_io({a, 2'b11}, r);
			byte_io(9'h1ff, r);
			r = {1'b0, r[8:1]};
		end
		else
			r = 9'h1ff;
		stop();
		rd_word <= r;
		rd_done <= 1'b1;
		@(posedge clk_sys);
		rd_done <= 1'b0;
	endtask
endmodule // i2c_host_model

// ==== bench/test_light_sensor_regs_irq.sv ====
// Self-checking bench of the light sensor register bank and event flag.
module test_light_sensor_regs_irq;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk_sys;
	logic        rst = 1'b1;
	logic        addr_select_pin = 1'b1;
	logic [11:0] adc_code = 12'h000;
	logic        scl, sda_low, rd_done, sda_o, sda_oe, int_n_o, int_n_oe;
	logic        divide_by_eight;
	logic [2:0]  integration_select;
	logic [8:0]  rd_word;
	logic [8:0]  exp_q[$];
	logic [6:0]  dev = 7'h4b;
	logic [7:0]  rst_tab[9] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'hff,
		8'h00, 8'hff, 8'h00};
	int          fails = 0;
	int          check_count = 0;
	wire         sda_wire = !(sda_low || (sda_oe && !sda_o));

	light_sensor_regs_irq #(
		.INTEG_MAX_CYCLES(1280),
		.PERSIST_STEP_CYCLES(20)
	) dut_u (
		.clk_sys(clk_sys), .rst(rst), .addr_select_pin(addr_select_pin),
		.scl_i(scl), .sda_i(sda_wire), .sda_o(sda_o), .sda_oe(sda_oe),
		.int_n_o(int_n_o), .int_n_oe(int_n_oe), .adc_code(adc_code),
		.integration_select(integration_select),
		.divide_by_eight(divide_by_eight)
	);
	i2c_host_model host_u (
		.clk_sys(clk_sys), .sda_line(sda_wire), .scl(scl),
		.sda_low(sda_low), .rd_done(rd_done), .rd_word(rd_word)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic check(input string what, input logic [8:0] e,
		input logic [8:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	// Two edges let the read monitor take the last result first.
	task automatic conclude();
		repeat (2) @(posedge clk_sys);
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic rd(input logic [7:0] p, input logic [8:0] e);
		exp_q.push_back(e);
		host_u.rd_reg(dev, p);
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		host_u.wr_reg(dev, p, d);
	endtask

	task automatic wait_int(input logic e);
		int n;
		n = 0;
		while (int_n_oe !== e && n < 4000)
		begin
			@(posedge clk_sys);
			n++;
		end
		check("int_n_oe", {8'h00, e}, {8'h00, int_n_oe});
		if (n >= 4000)
			conclude();
	endtask

	always @(posedge clk_sys)
		if (rd_done === 1'b1)
			check("read", exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx, rd_word);

	initial
	begin
		logic [7:0]  d;
		logic [11:0] a;
		void'($urandom(92864));
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (5) @(posedge clk_sys);
		check("tim", 9'h003, {6'h00, integration_select});
		for (int i = 0; i < 9; i++)
			if (i != 2)
				rd(8'(i), {1'b0, rst_tab[i]});
		for (int i = 5; i < 8; i++)
		begin
			d = 8'($urandom);
			wr(8'(i), d);
			rd(8'(i), {1'b0, d});
		end
		// Timing fields take a write only once manual mode is already stored.
		wr(8'h02, 8'h4d);
		wr(8'h02, 8'h4d);
		rd(8'h02, 9'h04d);
		check("tim", 9'h005, {6'h00, integration_select});
		check("cdr", 9'h001, {8'h00, divide_by_eight});
		wr(8'h02, 8'h07);
		check("auto tim", 9'h000, {8'h00, integration_select[2]});
		wr(8'h02, 8'h4d);
		rd(8'h02, 9'h047);
		wr(8'h02, 8'h00);
		a = {4'($urandom % 15), 8'($urandom)};
		adc_code <= a;
		wr(8'h03, ~a[11:4]);
		repeat (1400) @(posedge clk_sys);
		rd(8'h03, {1'b0, a[11:4]});
		rd(8'h04, {5'h00, a[3:0]});
		wr(8'h05, 8'h21);
		wr(8'h06, 8'h00);
		wr(8'h07, 8'h02);
		// A hit counts once per excursion, so bring the light inside first.
		adc_code <= 12'h010;
		repeat (1400) @(posedge clk_sys);
		wr(8'h01, 8'h01);
		adc_code <= 12'h380;
		wait_int(1'b1);
		rd(8'h00, 9'h001);
		check("int_n_oe", 9'h000, {8'h00, int_n_oe});
		for (int k = 0; k < 2; k++)
		begin
			adc_code <= 12'h010;
			repeat (1500) @(posedge clk_sys);
			adc_code <= 12'h380;
			if (k == 0)
				wait_int(1'b1);
			else
				repeat (1500) @(posedge clk_sys);
			wr(8'h01, 8'h00);
			check("int_n_oe", 9'h000, {8'h00, int_n_oe});
			rd(8'h00, 9'h000);
		end
		addr_select_pin <= 1'b0;
		rd(8'h01, 9'h1ff);
		dev = 7'h4a;
		rd(8'h07, 9'h002);
		conclude();
	end
endmodule // test_light_sensor_regs_irq
